// >>> shared/arcfe_consts.svh
// arcfe_consts.svh: register offsets, reset values, characters, limits and timing figures.
// assumes it is included by bare name from the package, from the top rtl file and from the testbench.
`ifndef ARCFE_CONSTS_SVH
`define ARCFE_CONSTS_SVH
// ==========================================================
// register map (byte addresses)
`define ARC_OFS_CFG     4'h0
`define ARC_OFS_DISP    4'h4
`define ARC_OFS_CPI     4'h8
`define ARC_OFS_STAT    4'hC
`define ARC_CFG_RST     15'h0001
`define ARC_DISP_RST    32'h0001_0000
`define ARC_CPI_RST     16'h0000
// ==========================================================
// characters and limits
`define ARC_CH_AT       8'h40
`define ARC_CH_CR       8'h0D
`define ARC_CH_LF       8'h0A
`define ARC_CH_0        8'h30
`define ARC_CH_9        8'h39
`define ARC_CH_H        8'h48
`define ARC_CH_Q        8'h3F
`define ARC_CH_F        8'h46
`define ARC_CH_V        8'h56
`define ARC_CH_S        8'h53
`define ARC_CH_A        8'h41
`define ARC_ADDR_NONE   10'd0
`define ARC_ADDR_ALL    10'd255
`define ARC_BUF_LEN     9
`define ARC_CODES_LEN   59
`define ARC_CODES_TXT   " I 00 01 02 03 04 05 09 10 13 14 15 L 00-09 P 00-02 V 00-01"
`define ARC_DISP_LEN    14
`define ARC_ID_LEN      20
// ==========================================================
// timing
`define ARC_CLK_HZ      125_000_000
`define ARC_BAUD_LIST   '{300, 600, 1200, 2400, 4800, 9600, 19200, 9600}
`define ARC_RATE_FAST   60
`define ARC_RATE_MID    30
`define ARC_RATE_SLOW   10
`define ARC_CPI_3DP     16'd1000
`define ARC_CPI_2DP     16'd100
`define ARC_CPI_1DP     16'd10
`endif

// >>> shared/arcfe_pkg.sv
// arcfe_pkg: carrier structs and state types of the command front end.
// assumes arcfe_consts.svh sits beside it.
`include "arcfe_consts.svh"
package arcfe_pkg;
	// config word: level 0..3 stands for filter level 1..4
	typedef struct packed {
		logic [1:0] flevel;
		logic       ftype;
		logic       lf_en;
		logic [2:0] baud;
		logic [7:0] addr;
	} arcfe_cfg_t;
	// display pairs, each code two bcd digits
	typedef struct packed {
		logic [7:0] alt_unit;
		logic [7:0] alt_item;
		logic [7:0] act_unit;
		logic [7:0] act_item;
	} arcfe_disp_t;
	typedef enum logic [1:0] {RP_IDLE = 2'b00, RP_SEND = 2'b01, RP_DONE = 2'b11} arcfe_rp_t;
	typedef enum logic [1:0] {RK_ID = 2'b00, RK_CODES = 2'b01, RK_DISP = 2'b11} arcfe_kind_t;
endpackage : arcfe_pkg

// >>> rtl/arcfe_uart.sv
// arcfe_uart: 8N1 receiver and transmitter with a run-time bit divisor.
// assumes rxd_in is synchronous to the clock and the reset is already synchronised.
`timescale 1ns/1ns
`default_nettype none
module arcfe_uart #(
	parameter int DIV_W = 20
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_b_in,
	input  wire logic [DIV_W-1:0] bit_div_in,
	input  wire logic             rxd_in,
	output logic      [7:0]       rx_data_out,
	output logic                  rx_valid_out,
	input  wire logic [7:0]       tx_data_in,
	input  wire logic             tx_valid_in,
	output logic                  tx_ready_out,
	output logic                  txd_out
);
	logic             rx_busy_q;
	logic [DIV_W-1:0] rx_cnt_q;
	logic [3:0]       rx_bit_q;
	logic [7:0]       rx_sh_q;
	logic [9:0]       tx_sh_q;
	logic [3:0]       tx_bits_q;
	logic [DIV_W-1:0] tx_cnt_q;

	// ==========================================================
	// receiver: start edge, half bit to centre, then whole bits
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rx_busy_q    <= 1'b0;
			rx_cnt_q     <= '0;
			rx_bit_q     <= 4'h0;
			rx_sh_q      <= 8'h00;
			rx_data_out  <= 8'h00;
			rx_valid_out <= 1'b0;
		end
		else
		begin
			rx_valid_out <= 1'b0;
			if (!rx_busy_q)
			begin
				if (!rxd_in)
				begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= bit_div_in >> 1;
					rx_bit_q  <= 4'h0;
				end
			end
			else if (rx_cnt_q != '0)
				rx_cnt_q <= rx_cnt_q - DIV_W'(1);
			else
			begin
				rx_cnt_q <= bit_div_in - DIV_W'(1);
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && rxd_in)
					rx_busy_q <= 1'b0; // glitch, not a start bit
				else if (rx_bit_q == 4'h9)
				begin
					rx_busy_q <= 1'b0;
					// a bad stop bit drops the character
					if (rxd_in)
					begin
						rx_data_out  <= rx_sh_q;
						rx_valid_out <= 1'b1;
					end
				end
				else if (rx_bit_q != 4'h0)
					rx_sh_q <= {rxd_in, rx_sh_q[7:1]}; // lsb first
			end
		end
	end

	// ==========================================================
	// transmitter: start, eight data, one stop, no parity
	assign tx_ready_out = (tx_bits_q == 4'h0);
	assign txd_out      = tx_sh_q[0];
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tx_sh_q   <= 10'h3FF;
			tx_bits_q <= 4'h0;
			tx_cnt_q  <= '0;
		end
		else if (tx_valid_in && tx_ready_out)
		begin
			tx_sh_q   <= {1'b1, tx_data_in, 1'b0};
			tx_bits_q <= 4'hA;
			tx_cnt_q  <= bit_div_in - DIV_W'(1);
		end
		else if (tx_bits_q != 4'h0)
		begin
			if (tx_cnt_q != '0)
				tx_cnt_q <= tx_cnt_q - DIV_W'(1);
			else
			begin
				tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
				tx_bits_q <= tx_bits_q - 4'h1;
				tx_cnt_q  <= bit_div_in - DIV_W'(1);
			end
		end
	end
endmodule : arcfe_uart
`default_nettype wire

// >>> rtl/arcfe_top.sv
// arcfe_top: ascii remote command front end with register slave and digital inputs.
// assumes avalon-mm master on clk_sys_in; digital inputs and rxd already clean and synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "arcfe_consts.svh"
module arcfe_top #(
	parameter int          CLK_HZ     = `ARC_CLK_HZ,
	parameter int          DIV_W      = 20,
	parameter int          RATE_DIV_W = 24, // must hold CLK_HZ/10 at the full clock
	parameter logic [159:0] ID_TEXT   = " UNIT-X V0.0 SN-0000" // value arbitrary
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_b_in,
	input  wire logic [3:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	output logic      [31:0]       avs_readdata_out,
	output logic                   avs_waitrequest_out,
	input  wire logic              rxd_in,
	output logic                   txd_out,
	input  wire logic              tare_input_in,
	input  wire logic              extremes_clear_input_in,
	input  wire logic              position_clear_input_in,
	input  wire logic              print_trigger_input_in,
	input  wire logic              view_button_in,
	output logic                   tare_hold_out,
	output logic                   extremes_clear_out,
	output logic                   position_clear_out,
	output logic                   print_request_out,
	output logic                   read_tick_out,
	output logic                   industrial_filter_out,
	output logic      [1:0]        filter_level_out,
	output logic      [1:0]        pos_decimals_out,
	output arcfe_pkg::arcfe_disp_t disp_out
);
	import arcfe_pkg::*;

	localparam int BAUD [8] = `ARC_BAUD_LIST;
	localparam logic [`ARC_CODES_LEN*8-1:0] CODES_VEC = `ARC_CODES_TXT;
	localparam int P_FAST = CLK_HZ / `ARC_RATE_FAST;
	localparam int P_MID  = CLK_HZ / `ARC_RATE_MID;
	localparam int P_SLOW = CLK_HZ / `ARC_RATE_SLOW;

	logic              rst_meta_q;
	logic              rst_sync_q;
	logic              ack_q;
	arcfe_cfg_t        cfg_q;
	arcfe_disp_t       disp_q;
	logic [15:0]       cpi_q;
	logic [7:0]        exec_cnt_q;
	logic [7:0]        rx_data;
	logic              rx_valid;
	logic              tx_ready;
	logic [7:0]        buf_q [`ARC_BUF_LEN];
	logic [3:0]        cnt_q;
	logic              in_frame_q;
	logic              ovf_q;
	logic              print_prev_q;
	logic [RATE_DIV_W-1:0] rate_cnt_q;
	arcfe_rp_t         rp_q;
	arcfe_kind_t       kind_q;
	logic [7:0]        idx_q;
	logic [7:0]        last_idx;
	logic [7:0]        body_len;
	logic [7:0]        tx_byte;
	logic [DIV_W-1:0]  bit_div;
	logic [9:0]        dst_addr;
	logic              addr_ok;
	logic              frame_end;
	logic              cmd_h;
	logic              cmd_list;
	logic              cmd_fv;
	logic              cmd_fs;
	logic              cmd_fa;
	logic              do_exec;
	logic [RATE_DIV_W-1:0] rate_top;
	logic [111:0]      disp_txt;

	// ==========================================================
	// reset release through two flops
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// avalon slave: one wait cycle, then answer
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			ack_q            <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= (avs_read_in || avs_write_in) && !ack_q;
			if (avs_read_in && !ack_q)
			begin
				case (avs_address_in)
					`ARC_OFS_CFG:  avs_readdata_out <= {17'h0_0000, cfg_q};
					`ARC_OFS_DISP: avs_readdata_out <= disp_q;
					`ARC_OFS_CPI:  avs_readdata_out <= {16'h0000, cpi_q};
					`ARC_OFS_STAT: avs_readdata_out <= {16'h0000, exec_cnt_q, 2'b00, (rp_q != RP_IDLE),
						in_frame_q, print_trigger_input_in, position_clear_input_in,
						extremes_clear_input_in, tare_input_in};
					default:       avs_readdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// config writes; an address of 0 or 255 is refused and the old one kept
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			cfg_q <= `ARC_CFG_RST;
			cpi_q <= `ARC_CPI_RST;
		end
		else if (avs_write_in && ack_q)
		begin
			if (avs_address_in == `ARC_OFS_CFG)
			begin
				cfg_q.baud   <= avs_writedata_in[10:8];
				cfg_q.lf_en  <= avs_writedata_in[11];
				cfg_q.ftype  <= avs_writedata_in[12];
				cfg_q.flevel <= avs_writedata_in[14:13];
				if (avs_writedata_in[7:0] != 8'h00 && avs_writedata_in[7:0] != 8'hFF)
					cfg_q.addr <= avs_writedata_in[7:0];
			end
			if (avs_address_in == `ARC_OFS_CPI)
				cpi_q <= avs_writedata_in[15:0];
		end
	end

	// ==========================================================
	// serial link; the reserved eighth rate code falls back to 9600
	assign bit_div = DIV_W'(CLK_HZ / BAUD[cfg_q.baud]);
	arcfe_uart #(
		.DIV_W (DIV_W)
	) u_uart (
		.clk_sys_in   (clk_sys_in),
		.rst_b_in     (rst_sync_q),
		.bit_div_in   (bit_div),
		.rxd_in       (rxd_in),
		.rx_data_out  (rx_data),
		.rx_valid_out (rx_valid),
		.tx_data_in   (tx_byte),
		.tx_valid_in  (rp_q == RP_SEND),
		.tx_ready_out (tx_ready),
		.txd_out      (txd_out)
	);

	// ==========================================================
	// framing: at-sign restarts, carriage return closes
	assign frame_end = rx_valid && rx_data == `ARC_CH_CR && in_frame_q;
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			cnt_q      <= 4'h0;
			in_frame_q <= 1'b0;
			ovf_q      <= 1'b0;
			for (int i = 0; i < `ARC_BUF_LEN; i++)
				buf_q[i] <= 8'h00;
		end
		else if (rx_valid)
		begin
			if (rx_data == `ARC_CH_AT)
			begin
				in_frame_q <= 1'b1;
				cnt_q      <= 4'h0;
				ovf_q      <= 1'b0;
			end
			else if (rx_data == `ARC_CH_CR)
				in_frame_q <= 1'b0;
			else if (in_frame_q)
			begin
				// parameter chars, pound sign included, are only buffered
				if (cnt_q < 4'(`ARC_BUF_LEN))
				begin
					buf_q[cnt_q] <= rx_data;
					cnt_q        <= cnt_q + 4'h1;
				end
				else
					ovf_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// decode: three digits, then letters; digits checked by function
	function automatic logic is_dig(input logic [7:0] c);
		is_dig = (c >= `ARC_CH_0) && (c <= `ARC_CH_9);
	endfunction : is_dig

	assign dst_addr = 10'(buf_q[0][3:0]) * 10'd100 + 10'(buf_q[1][3:0]) * 10'd10
		+ 10'(buf_q[2][3:0]);
	// own address or broadcast, never zero; others dropped silently
	assign addr_ok = is_dig(buf_q[0]) && is_dig(buf_q[1]) && is_dig(buf_q[2]) && !ovf_q
		&& dst_addr != `ARC_ADDR_NONE
		&& (dst_addr == `ARC_ADDR_ALL || dst_addr == 10'(cfg_q.addr));
	assign cmd_h  = cnt_q == 4'd4 && buf_q[3] == `ARC_CH_H;
	assign cmd_list = cnt_q == 4'd4 && buf_q[3] == `ARC_CH_Q;
	assign cmd_fv = cnt_q == 4'd5 && buf_q[3] == `ARC_CH_F && buf_q[4] == `ARC_CH_V;
	assign cmd_fa = cnt_q == 4'd5 && buf_q[3] == `ARC_CH_F && buf_q[4] == `ARC_CH_A;
	assign cmd_fs = cnt_q == 4'd9 && buf_q[3] == `ARC_CH_F && buf_q[4] == `ARC_CH_S
		&& is_dig(buf_q[5]) && is_dig(buf_q[6]) && is_dig(buf_q[7]) && is_dig(buf_q[8]);
	// a frame that closes while a reply is going out is dropped, not queued
	assign do_exec = frame_end && addr_ok && rp_q == RP_IDLE
		&& (cmd_h || cmd_list || cmd_fv || cmd_fa || cmd_fs);

	// ==========================================================
	// display pairs: set, swap from link or view button
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			disp_q <= `ARC_DISP_RST;
		else if (do_exec && cmd_fs)
		begin
			disp_q.act_item <= {buf_q[5][3:0], buf_q[6][3:0]};
			disp_q.act_unit <= {buf_q[7][3:0], buf_q[8][3:0]};
		end
		else if ((do_exec && cmd_fa) || view_button_in)
			disp_q <= {disp_q.act_unit, disp_q.act_item, disp_q.alt_unit, disp_q.alt_item};
	end
	assign disp_out = disp_q;

	// ==========================================================
	// reply sequencer: prefix, body, cr, optional lf
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			rp_q       <= RP_IDLE;
			kind_q     <= RK_ID;
			idx_q      <= 8'h00;
			exec_cnt_q <= 8'h00;
		end
		else
		begin
			case (rp_q)
				RP_IDLE:
				begin
					if (do_exec)
					begin
						rp_q       <= RP_SEND;
						idx_q      <= 8'h00;
						exec_cnt_q <= exec_cnt_q + 8'h01;
						kind_q     <= cmd_h ? RK_ID : (cmd_list ? RK_CODES : RK_DISP);
					end
				end
				RP_SEND:
				begin
					if (tx_ready)
					begin
						idx_q <= idx_q + 8'h01;
						if (idx_q == last_idx)
							rp_q <= RP_DONE;
					end
				end
				RP_DONE:
					rp_q <= RP_IDLE;
				default:
					rp_q <= RP_IDLE;
			endcase
		end
	end

	// body text of the display answer, built from the live pairs
	assign disp_txt = {" A=", 4'h3, disp_q.act_item[7:4], 4'h3, disp_q.act_item[3:0],
		4'h3, disp_q.act_unit[7:4], 4'h3, disp_q.act_unit[3:0],
		" O=", 4'h3, disp_q.alt_item[7:4], 4'h3, disp_q.alt_item[3:0],
		4'h3, disp_q.alt_unit[7:4], 4'h3, disp_q.alt_unit[3:0]};
	always_comb
	begin
		case (kind_q)
			RK_ID:    body_len = 8'(`ARC_ID_LEN);
			RK_CODES: body_len = 8'(`ARC_CODES_LEN);
			default:  body_len = 8'(`ARC_DISP_LEN);
		endcase
	end
	assign last_idx = 8'h04 + body_len + {7'h00, cfg_q.lf_en};

	// byte picker: reply always opens with at-sign and own address
	always_comb
	begin
		logic [7:0] j;
		j = idx_q - 8'h04;
		tx_byte = `ARC_CH_LF;
		if (idx_q == 8'h00)
			tx_byte = `ARC_CH_AT;
		else if (idx_q == 8'h01)
			tx_byte = `ARC_CH_0 + 8'(cfg_q.addr / 8'd100);
		else if (idx_q == 8'h02)
			tx_byte = `ARC_CH_0 + 8'((cfg_q.addr / 8'd10) % 8'd10);
		else if (idx_q == 8'h03)
			tx_byte = `ARC_CH_0 + 8'(cfg_q.addr % 8'd10);
		else if (j < body_len)
		begin
			case (kind_q)
				RK_ID:    tx_byte = ID_TEXT[(`ARC_ID_LEN - 1 - int'(j)) * 8 +: 8];
				RK_CODES: tx_byte = CODES_VEC[(`ARC_CODES_LEN - 1 - int'(j)) * 8 +: 8];
				default:  tx_byte = disp_txt[(`ARC_DISP_LEN - 1 - int'(j)) * 8 +: 8];
			endcase
		end
		else if (j == body_len)
			tx_byte = `ARC_CH_CR;
	end

	// ==========================================================
	// digital inputs: three levels held, print on rising edge only
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			tare_hold_out      <= 1'b0;
			extremes_clear_out <= 1'b0;
			position_clear_out <= 1'b0;
			print_prev_q       <= 1'b0;
			print_request_out  <= 1'b0;
		end
		else
		begin
			tare_hold_out      <= tare_input_in;
			extremes_clear_out <= extremes_clear_input_in;
			position_clear_out <= position_clear_input_in;
			print_prev_q       <= print_trigger_input_in;
			print_request_out  <= print_trigger_input_in && !print_prev_q;
		end
	end

	// ==========================================================
	// read rate tick from filter level
	always_comb
	begin
		case (cfg_q.flevel)
			2'd2:    rate_top = RATE_DIV_W'(P_MID - 1);
			2'd3:    rate_top = RATE_DIV_W'(P_SLOW - 1);
			default: rate_top = RATE_DIV_W'(P_FAST - 1);
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			rate_cnt_q    <= '0;
			read_tick_out <= 1'b0;
		end
		else
		begin
			read_tick_out <= (rate_cnt_q >= rate_top);
			rate_cnt_q    <= (rate_cnt_q >= rate_top) ? '0 : rate_cnt_q + RATE_DIV_W'(1);
		end
	end
	assign industrial_filter_out = cfg_q.ftype;
	assign filter_level_out      = cfg_q.flevel;

	// position decimals from counts per inch alone
	always_ff @(posedge clk_sys_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			pos_decimals_out <= 2'd0;
		else if (cpi_q >= `ARC_CPI_3DP)
			pos_decimals_out <= 2'd3;
		else if (cpi_q >= `ARC_CPI_2DP)
			pos_decimals_out <= 2'd2;
		else if (cpi_q >= `ARC_CPI_1DP)
			pos_decimals_out <= 2'd1;
		else
			pos_decimals_out <= 2'd0;
	end
endmodule : arcfe_top
`default_nettype wire

// >>> test/arcfe_host.sv
// arcfe_host: terminal model on the far end of the serial link.
// assumes the front end runs its link at BIT clock cycles per bit.
`timescale 1ns/1ns
`default_nettype none
module arcfe_host #(
	parameter int BIT = 5
) (
	input  wire logic clk_sys_in,
	input  wire logic txd_in,
	output logic      rxd_out
);
	logic [7:0] rx_q [$];
	initial rxd_out = 1'b1;
	// ==========================================================
	// transmit: start bit, eight data bits lsb first, one stop bit
	task automatic put(input logic [7:0] c);
		for (int i = 0; i < 10; i++)
		begin
			rxd_out <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : c[i-1]);
			repeat (BIT) @(posedge clk_sys_in);
		end
	endtask : put
	// ==========================================================
	// receive: sample mid-bit; a bad stop bit drops the character
	always
	begin
		logic [7:0] b;
		@(negedge txd_in);
		repeat (BIT / 2) @(posedge clk_sys_in);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk_sys_in);
			b[i] = txd_in;
		end
		repeat (BIT) @(posedge clk_sys_in);
		if (txd_in === 1'b1)
			rx_q.push_back(b);
	end
endmodule : arcfe_host
`default_nettype wire

// >>> test/arcfe_top_props.sv
// arcfe_top_props: port-level timing checks of the front end.
// assumes it is bound into arcfe_top; one clock, active low reset.
`timescale 1ns/1ns
`default_nettype none
module arcfe_top_props
	import arcfe_pkg::*;
(
	input wire logic                   clk_sys_in,
	input wire logic                   rst_b_in,
	input wire logic                   avs_read_in,
	input wire logic                   avs_write_in,
	input wire logic                   avs_waitrequest_out,
	input wire logic                   tare_input_in,
	input wire logic                   extremes_clear_input_in,
	input wire logic                   position_clear_input_in,
	input wire logic                   print_trigger_input_in,
	input wire logic                   view_button_in,
	input wire logic                   tare_hold_out,
	input wire logic                   extremes_clear_out,
	input wire logic                   position_clear_out,
	input wire logic                   print_request_out,
	input wire logic                   read_tick_out,
	input wire arcfe_pkg::arcfe_disp_t disp_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// ==========================================================
	// digital inputs: levels held, print only on a rising edge
	tare_copy_a: assert property (tare_hold_out == $past(tare_input_in)) else $error("tare hold");
	extr_hold_a: assert property (extremes_clear_input_in |=> extremes_clear_out) else $error("extremes");
	pos_free_a: assert property (!position_clear_input_in |=> !position_clear_out) else $error("pos");
	print_rise_a: assert property ($rose(print_trigger_input_in) |=> print_request_out) else $error("no print");
	print_once_a: assert property (print_request_out |=> !print_request_out) else $error("print long");
	print_cause_a: assert property (print_request_out |-> $past(print_trigger_input_in)
		&& !$past(print_trigger_input_in, 2)) else $error("print cause");
	// ==========================================================
	// bus answers after exactly one wait cycle
	wait_first_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
		else $error("no wait");
	wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("wait long");
	// ==========================================================
	// view swap exchanges pairs; reading tick is a lone pulse
	view_swap_a: assert property (view_button_in |=> disp_out == {$past(disp_out[15:0]),
		$past(disp_out[31:16])}) else $error("swap");
	tick_gap_a: assert property (read_tick_out |=> !read_tick_out [*8]) else $error("tick");
	c_print: cover property (print_request_out);
	c_view: cover property (view_button_in);
	c_tick: cover property (read_tick_out);
endmodule : arcfe_top_props
`default_nettype wire

// >>> test/testbench.sv
// testbench: drives the front end over its register bus, link and inputs.
// assumes arcfe_host on the link and arcfe_top_props bound to the top.
`timescale 1ns/1ns
`default_nettype none
`include "arcfe_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
	import arcfe_pkg::*;
	logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [3:0]  avs_address_in = 4'h0, din = 4'h0;
	logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, q;
	logic        avs_waitrequest_out, rxd_in, txd_out, view_button_in = 1'b0;
	logic        tare_hold_out, extremes_clear_out, position_clear_out, print_request_out;
	logic        read_tick_out, industrial_filter_out;
	logic [1:0]  filter_level_out, pos_decimals_out;
	arcfe_disp_t disp_out;
	int          n_errors = 0, checks_done = 0, n_print = 0, n;
	bit          lf_on = 1'b0;
	// command rows beside the reply each should give; empty means silence
	string rows [9][2] = '{'{"@123FV", "@123 A=0000 O=0100"}, '{"@123FS0200", "@123 A=0200 O=0100"},
		'{"@123FA", "@123 A=0100 O=0200"}, '{"@255FV", "@123 A=0100 O=0200"}, '{"@000FV", ""},
		'{"@124FV", ""}, '{"@123FS02001", ""}, '{"@12@123H", "@123 UNIT-X V0.0 SN-0000"},
		'{"@123?", {"@123", `ARC_CODES_TXT}}};
	int          cpi [5] = '{1000, 999, 100, 10, 9};
	logic [1:0]  dec [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h0};
	logic [31:0] rv [4] = '{32'h0000_0001, 32'h0001_0000, 32'h0000_0000, 32'h0000_0000};
	int          per [4] = '{1600, 1600, 3200, 9600};
	arcfe_top #(.CLK_HZ(96_000)) DUT (.clk_sys_in, .rst_b_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .rxd_in, .txd_out,
		.tare_input_in(din[0]), .extremes_clear_input_in(din[1]), .position_clear_input_in(din[2]),
		.print_trigger_input_in(din[3]), .view_button_in, .tare_hold_out, .extremes_clear_out,
		.position_clear_out, .print_request_out, .read_tick_out, .industrial_filter_out,
		.filter_level_out, .pos_decimals_out, .disp_out);
	arcfe_host #(.BIT(5)) u_host (.clk_sys_in, .txd_in(txd_out), .rxd_out(rxd_in));
	always #4 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (print_request_out === 1'b1) n_print++;
	// ==========================================================
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !w;
		avs_write_in <= w;
		// no cycle count assumed: only the watchdog ends a stuck wait
		do
		begin
			@(posedge clk_sys_in);
		end
		while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask : bus
	// send a frame then wait for the whole reply, or for silence
	task automatic frame(input string c, input string r);
		string t;
		int k;
		t = (r == "") ? "" : {r, "\r", lf_on ? "\n" : ""};
		u_host.rx_q.delete();
		foreach (c[i]) u_host.put(c[i]);
		u_host.put(`ARC_CH_CR);
		k = 0;
		while ((u_host.rx_q.size() < t.len() || t == "") && k < 4000)
		begin
			@(posedge clk_sys_in);
			k++;
		end
		`CHK(c, t.len(), u_host.rx_q.size())
		foreach (t[i]) if (i < u_host.rx_q.size()) `CHK(c, t[i], u_host.rx_q[i])
	endtask : frame
	task automatic tick();
		n = 0;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (read_tick_out !== 1'b1 && n < 20000);
	endtask : tick
	task automatic results();
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	initial
	begin
		repeat (100000) @(posedge clk_sys_in);
		n_errors++;
		results();
	end
	// ==========================================================
	// main sequence: reset values, command rows, then awkward cases
	initial
	begin
		repeat (16) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		`CHK("disp rst", 32'h0001_0000, disp_out)
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, (i == 3) ? 4'h6 : 4'(i * 4), 32'h0000_0000);
			`CHK("reg rst", rv[i], q)
		end
		bus(1'b1, 4'h0, 32'h0000_067B);
		foreach (rows[i]) frame(rows[i][0], rows[i][1]);
		`CHK("disp", 32'h0002_0001, disp_out)
		view_button_in <= 1'b1;
		@(posedge clk_sys_in);
		view_button_in <= 1'b0;
		@(posedge clk_sys_in);
		bus(1'b0, 4'h4, 32'h0000_0000);
		`CHK("disp reg", 32'h0001_0002, q)
		bus(1'b1, 4'h0, 32'h0000_0E7B);
		lf_on = 1'b1;
		frame("@123FV", "@123 A=0200 O=0100");
		// address zero and broadcast are refused as unit addresses
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, 4'h0, 32'h0000_0E00 | 32'(i * 255));
			bus(1'b0, 4'h0, 32'h0000_0000);
			`CHK("cfg addr", 32'h0000_0E7B, q)
		end
		for (int lv = 0; lv < 4; lv++)
		begin
			bus(1'b1, 4'h0, 32'h0000_067B | (32'(lv) << 13) | (32'(lv[0]) << 12));
			`CHK("level", 2'(lv), filter_level_out)
			`CHK("type", lv[0], industrial_filter_out)
			tick();
			tick();
			`CHK("tick gap", per[lv], n)
		end
		// held inputs, then print trigger twice with a long high phase
		din <= 4'h7;
		repeat (3) @(posedge clk_sys_in);
		`CHK("holds", 3'h7, {position_clear_out, extremes_clear_out, tare_hold_out})
		bus(1'b0, 4'hC, 32'h0000_0000);
		`CHK("stat", 4'h7, q[3:0])
		din <= 4'hF;
		repeat (20) @(posedge clk_sys_in);
		din <= 4'h7;
		repeat (5) @(posedge clk_sys_in);
		din <= 4'hF;
		repeat (5) @(posedge clk_sys_in);
		din <= 4'h0;
		repeat (5) @(posedge clk_sys_in);
		`CHK("prints", 2, n_print)
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, 4'h8, 32'(cpi[i]));
			@(posedge clk_sys_in);
			`CHK("decimals", dec[i], pos_decimals_out)
		end
		results();
	end
endmodule : testbench
bind arcfe_top arcfe_top_props u_props (.clk_sys_in, .rst_b_in, .avs_read_in, .avs_write_in,
	.avs_waitrequest_out, .tare_input_in, .extremes_clear_input_in, .position_clear_input_in,
	.print_trigger_input_in, .view_button_in, .tare_hold_out, .extremes_clear_out,
	.position_clear_out, .print_request_out, .read_tick_out, .disp_out);
`default_nettype wire
